// ### vcdf_capture_buffer.sv
// Byte-swap stage, tag generation and three-segment capture buffer with AHB-Lite registers.
// Function
// RL1: Four-way mux swaps bytes, halves, or both.
// RL2: Byte lane zero stays first scan byte.
// RL3: VBI words bypass the swap mux.
// RL4: Three 36-bit segments: 70, 35, 35 words.
// RL5: Word in 31:0, tag in 35:32.
// RL6: Write only valid active-field pixels.
// RL7: Enabled VBI words stored like pixels.
// RL8: Mode markers 0110 packed, 1110 planar.
// RL9: Line start tag 0010 on first word.
// RL10: Line end tag encodes one to four bytes.
// RL11: Field end tag 0100 even, 1100 odd; code writes 1100 when an even field ends and 0100 when an odd field ends.
// RL12: Untagged valid words carry tag 0000.
// RL13: Marker at field start, format change, enable.
// RL14: Markers: two primary copies, one elsewhere.
// RL15: Line end tag on last written word.
// RL16: Writes and reads proceed concurrently, isolated.
// RL17: Reader keeps buffer from filling; no overrun action.
// RL18: All segment heads presented in parallel.
// RL19: Full at 68 primary, 34 others.
// RL20: Almost full at 64 primary, 32 others.
// RL21: Reader reads in the full cycle.
// RL22: Planar independent, packed merged 140 words.
// RL23: Fill count tracks writes, reads; FIFO order.
// RL24: Reset empties segments and clears flags.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps

module vcdf_segment
   import vcdf_pkg::*;
#(
   parameter int unsigned DEPTH    = PRI_DEPTH,
   parameter int unsigned FULL_AT  = PRI_FULL,
   parameter int unsigned AFULL_AT = PRI_AFULL,
   parameter int unsigned CNT_W    = $clog2(DEPTH + 1)
)(
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               wr_en,
   input  wire logic [ENTRY_W-1:0] wr_entry,
   input  wire logic               rd_en,
   output logic      [ENTRY_W-1:0] head,
   output logic                    empty,
   output logic                    full_flag,
   output logic                    almost_full_flag,
   output logic      [CNT_W-1:0]   fill_count
);
   localparam int unsigned PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CAP      = CNT_W'(DEPTH);
   localparam logic [CNT_W-1:0] FULL_C   = CNT_W'(FULL_AT);
   localparam logic [CNT_W-1:0] AFULL_C  = CNT_W'(AFULL_AT);

   logic [ENTRY_W-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0]   wr_ptr_reg;
   logic [PTR_W-1:0]   rd_ptr_reg;
   logic [CNT_W-1:0]   count_reg;
   logic               do_rd;
   logic               overrun;

   assign do_rd   = rd_en && (count_reg != '0);
   // No overrun protection: a write into a physically full segment drops the oldest entry.
   assign overrun = wr_en && !do_rd && (count_reg == CAP); // [RL17] [RL21]

   always_ff @(posedge hclk)
   begin
      if (wr_en)
      begin
         mem_reg[wr_ptr_reg] <= wr_entry;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0; // [RL24]
      end
      else
      begin
         if (wr_en)
         begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (do_rd || overrun)
         begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1; // [RL23]
         end
         if (wr_en && !do_rd && !overrun)
         begin
            count_reg <= count_reg + 1'b1; // [RL23]
         end
         else if (do_rd && !wr_en)
         begin
            count_reg <= count_reg - 1'b1; // [RL23]
         end
      end
   end

   assign head             = mem_reg[rd_ptr_reg]; // [RL18]
   assign empty            = (count_reg == '0);
   assign full_flag        = (count_reg >= FULL_C);  // [RL19]
   assign almost_full_flag = (count_reg >= AFULL_C); // [RL20]
   assign fill_count       = count_reg;
endmodule

module vcdf_capture_buffer
   import vcdf_pkg::*;
(
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic      [1:0]              hresp,
   output logic      [31:0]             hrdata,
   input  wire vcdf_pix_s               pix_in,
   input  wire logic                    pix_toggle,
   input  wire logic                    field_odd,
   input  wire logic [SEG_COUNT-1:0]    seg_read,
   output logic      [ENTRY_W-1:0]      seg_head [SEG_COUNT],
   output logic      [SEG_COUNT-1:0]    seg_empty,
   output logic      [SEG_COUNT-1:0]    full_flag,
   output logic      [SEG_COUNT-1:0]    almost_full_flag
);
   localparam int unsigned PRI_CW = $clog2(PRI_DEPTH + 1);
   localparam int unsigned SEC_CW = $clog2(SEC_DEPTH + 1);
   localparam logic [SEG_COUNT-1:0] SEG_ALL  = 3'h7;
   localparam logic [SEG_COUNT-1:0] SEG_PRI  = 3'h1;
   localparam logic [SEG_COUNT-1:0] SEG_SEC  = 3'h2;
   localparam logic [SEG_COUNT-1:0] SEG_THI  = 3'h4;
   localparam logic [1:0]           PLANE_CB = 2'h1;
   localparam logic [1:0]           PLANE_CR = 2'h2;

   vcdf_ctrl_s         ctrl_reg;
   logic               ap_wr_reg;
   logic               ap_rd_reg;
   logic [31:0]        ap_addr_reg;
   logic               ap_take;

   vcdf_pix_s          pix_s1_reg;
   vcdf_pix_s          pix_s2_reg;
   logic               tog_s1_reg;
   logic               tog_s2_reg;
   logic               tog_s3_reg;
   logic               fld_s1_reg;
   logic               fld_s2_reg;
   logic               fld_s3_reg;
   logic               new_word;
   logic               field_edge;

   vcdf_wr_state_e     state_reg;
   vcdf_pix_s          held_reg;
   logic               held_vbi_mode;
   logic               word_pend_reg;
   logic               mark_pend_reg;
   logic               end_pend_reg;
   logic [3:0]         end_tag_reg;
   logic               cap_field_reg;
   logic               cap_prev_reg;
   logic               mode_planar_reg;
   logic [1:0]         pk_idx_reg;
   logic               word_ok;
   logic               held_planar;

   logic [SEG_COUNT-1:0] wr_en;
   logic [ENTRY_W-1:0]   wr_entry;
   logic [WORD_W-1:0]    swapped;
   logic [TAG_W-1:0]     word_tag;
   logic [SEG_COUNT-1:0] word_seg;
   logic [PRI_CW-1:0]    cnt_pri;
   logic [SEC_CW-1:0]    cnt_sec;
   logic [SEC_CW-1:0]    cnt_thi;

   // AHB-Lite slave: zero wait states, always OKAY, word writes only.
   assign ap_take   = hsel && hready && (htrans == HTRANS_NSEQ);
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_wr_reg   <= 1'b0;
         ap_rd_reg   <= 1'b0;
         ap_addr_reg <= '0;
      end
      else if (hready)
      begin
         ap_wr_reg   <= ap_take && hwrite && (hsize == HSIZE_WORD);
         ap_rd_reg   <= ap_take && !hwrite;
         ap_addr_reg <= haddr & ADDR_MASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg <= CTRL_RESET;
      end
      else if (ap_wr_reg && (ap_addr_reg == ADDR_CTRL))
      begin
         ctrl_reg <= hwdata[CTRL_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= '0;
      end
      else if (ap_take && !hwrite)
      begin
         case (haddr & ADDR_MASK)
            ADDR_CTRL:   hrdata <= {27'h0000000, ctrl_reg};
            ADDR_STATUS: hrdata <= {23'h000000, seg_empty, almost_full_flag, full_flag};
            ADDR_COUNT:  hrdata <= {13'h0000, cnt_thi, cnt_sec, cnt_pri};
            default:     hrdata <= '0;
         endcase
      end
   end

   // Formatter side is asynchronous: data, toggle and field cross through two flops.
   // The formatter must hold the word stable from before its toggle until it is taken.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pix_s1_reg <= '0;
         pix_s2_reg <= '0;
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
         fld_s1_reg <= 1'b0;
         fld_s2_reg <= 1'b0;
         fld_s3_reg <= 1'b0;
      end
      else
      begin
         pix_s1_reg <= pix_in; // [RL16]
         pix_s2_reg <= pix_s1_reg;
         tog_s1_reg <= pix_toggle;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
         fld_s1_reg <= field_odd;
         fld_s2_reg <= fld_s1_reg;
         fld_s3_reg <= fld_s2_reg;
      end
   end

   assign new_word   = tog_s2_reg ^ tog_s3_reg;
   assign field_edge = fld_s2_reg ^ fld_s3_reg;
   assign word_ok    = cap_field_reg && ctrl_reg.capture &&
                       ((pix_s2_reg.active && !pix_s2_reg.vbi) ||
                        (pix_s2_reg.vbi && ctrl_reg.vbi_en)); // [RL6] [RL7]
   assign held_vbi_mode = held_reg.vbi;
   assign held_planar   = ctrl_reg.planar && !held_vbi_mode;

   // Field and enable tracking; pending flags let a new event win over its own clear.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cap_field_reg <= 1'b0;
         cap_prev_reg  <= 1'b0;
         end_pend_reg  <= 1'b0;
         end_tag_reg   <= TAG_PLAIN;
         mark_pend_reg <= 1'b0;
         word_pend_reg <= 1'b0;
         held_reg      <= '0;
      end
      else
      begin
         cap_prev_reg <= ctrl_reg.capture;
         if (field_edge)
         begin
            cap_field_reg <= ctrl_reg.capture;
         end
         else if (ctrl_reg.capture && !cap_prev_reg)
         begin
            cap_field_reg <= 1'b1;
         end
         else if (!ctrl_reg.capture)
         begin
            cap_field_reg <= 1'b0;
         end

         if (field_edge && cap_field_reg)
         begin
            end_pend_reg <= 1'b1;
            end_tag_reg  <= fld_s3_reg ? TAG_EVEN_END : TAG_ODD_END; // [RL11]
         end
         else if (state_reg == ST_FIELD_END)
         begin
            end_pend_reg <= 1'b0;
         end

         if ((field_edge || !cap_prev_reg) && ctrl_reg.capture)
         begin
            mark_pend_reg <= 1'b1; // [RL13]
         end
         else if (state_reg == ST_MARK_B)
         begin
            mark_pend_reg <= 1'b0;
         end

         if (new_word && word_ok)
         begin
            word_pend_reg <= 1'b1;
            held_reg      <= pix_s2_reg;
         end
         else if (state_reg == ST_WORD)
         begin
            word_pend_reg <= 1'b0;
         end
      end
   end

   // Write sequencer: field end first, then any marker, then the held word.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg       <= ST_IDLE;
         mode_planar_reg <= 1'b0;
         pk_idx_reg      <= 2'h0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (end_pend_reg)
               begin
                  state_reg <= ST_FIELD_END;
               end
               else if (mark_pend_reg)
               begin
                  state_reg <= ST_MARK_A;
               end
               else if (word_pend_reg && (held_planar != mode_planar_reg))
               begin
                  state_reg <= ST_MARK_A; // [RL13]
               end
               else if (word_pend_reg)
               begin
                  state_reg <= ST_WORD;
               end
            end
            ST_MARK_A:
            begin
               mode_planar_reg <= word_pend_reg ? held_planar : ctrl_reg.planar;
               pk_idx_reg      <= 2'h0;
               state_reg       <= ST_MARK_B;
            end
            ST_MARK_B:    state_reg <= ST_IDLE;
            ST_FIELD_END:
            begin
               pk_idx_reg <= 2'h0;
               state_reg  <= ST_IDLE;
            end
            ST_WORD:
            begin
               pk_idx_reg <= pk_idx_reg + 2'h1;
               state_reg  <= ST_IDLE;
            end
            default:      state_reg <= ST_IDLE;
         endcase
      end
   end

   always_comb
   begin
      swapped = held_reg.formatter_pixel_word;
      if (!held_reg.vbi) // [RL3]
      begin
         case ({ctrl_reg.word_swap, ctrl_reg.byte_swap}) // [RL1] [RL2]
            2'b01: swapped = {held_reg.formatter_pixel_word[23:16],
                              held_reg.formatter_pixel_word[31:24],
                              held_reg.formatter_pixel_word[7:0],
                              held_reg.formatter_pixel_word[15:8]};
            2'b10: swapped = {held_reg.formatter_pixel_word[15:0],
                              held_reg.formatter_pixel_word[31:16]};
            2'b11: swapped = {held_reg.formatter_pixel_word[7:0],
                              held_reg.formatter_pixel_word[15:8],
                              held_reg.formatter_pixel_word[23:16],
                              held_reg.formatter_pixel_word[31:24]};
            default: swapped = held_reg.formatter_pixel_word;
         endcase
      end
   end

   always_comb
   begin
      // A one-word line takes the end tag, since the byte count matters more to the reader.
      if (held_reg.line_end) // [RL10] [RL15]
      begin
         case (held_reg.valid_bytes)
            2'h1:    word_tag = TAG_END_1B;
            2'h2:    word_tag = TAG_END_2B;
            2'h3:    word_tag = TAG_END_3B;
            default: word_tag = TAG_END_4B;
         endcase
      end
      else if (held_reg.line_start)
      begin
         word_tag = TAG_LINE_START; // [RL9]
      end
      else
      begin
         word_tag = TAG_PLAIN; // [RL12]
      end
   end

   // Packed mode spreads words F1,F2,F1,F3 so the segments act as one merged buffer.
   always_comb
   begin
      if (mode_planar_reg) // [RL22]
      begin
         case (held_reg.plane)
            PLANE_CB: word_seg = SEG_SEC;
            PLANE_CR: word_seg = SEG_THI;
            default:  word_seg = SEG_PRI;
         endcase
      end
      else
      begin
         case (pk_idx_reg)
            2'h1:    word_seg = SEG_SEC;
            2'h3:    word_seg = SEG_THI;
            default: word_seg = SEG_PRI;
         endcase
      end
   end

   always_comb
   begin
      wr_en    = '0;
      wr_entry = '0;
      case (state_reg)
         ST_MARK_A:
         begin
            wr_en    = SEG_ALL; // [RL14]
            wr_entry = {(word_pend_reg ? held_planar : ctrl_reg.planar) ?
                        TAG_PLANAR_MARK : TAG_PACKED_MARK, 32'h00000000}; // [RL8]
         end
         ST_MARK_B:
         begin
            wr_en    = SEG_PRI; // [RL14]
            wr_entry = {mode_planar_reg ? TAG_PLANAR_MARK : TAG_PACKED_MARK, 32'h00000000};
         end
         ST_FIELD_END:
         begin
            wr_en    = SEG_ALL;
            wr_entry = {end_tag_reg, 32'h00000000}; // [RL11]
         end
         ST_WORD:
         begin
            wr_en    = word_seg;
            wr_entry = {word_tag, swapped}; // [RL5]
         end
         default:
         begin
            wr_en    = '0;
            wr_entry = '0;
         end
      endcase
   end

   vcdf_segment #(
      .DEPTH    (PRI_DEPTH),
      .FULL_AT  (PRI_FULL),
      .AFULL_AT (PRI_AFULL)
   ) u_primary_segment ( // [RL4]
      .hclk             (hclk),
      .hresetn          (hresetn),
      .wr_en            (wr_en[0]),
      .wr_entry         (wr_entry),
      .rd_en            (seg_read[0]), // [RL16]
      .head             (seg_head[0]),
      .empty            (seg_empty[0]),
      .full_flag        (full_flag[0]),
      .almost_full_flag (almost_full_flag[0]),
      .fill_count       (cnt_pri)
   );

   vcdf_segment #(
      .DEPTH    (SEC_DEPTH),
      .FULL_AT  (SEC_FULL),
      .AFULL_AT (SEC_AFULL)
   ) u_second_segment ( // [RL4]
      .hclk             (hclk),
      .hresetn          (hresetn),
      .wr_en            (wr_en[1]),
      .wr_entry         (wr_entry),
      .rd_en            (seg_read[1]),
      .head             (seg_head[1]),
      .empty            (seg_empty[1]),
      .full_flag        (full_flag[1]),
      .almost_full_flag (almost_full_flag[1]),
      .fill_count       (cnt_sec)
   );

   vcdf_segment #(
      .DEPTH    (SEC_DEPTH),
      .FULL_AT  (SEC_FULL),
      .AFULL_AT (SEC_AFULL)
   ) u_third_segment ( // [RL4]
      .hclk             (hclk),
      .hresetn          (hresetn),
      .wr_en            (wr_en[2]),
      .wr_entry         (wr_entry),
      .rd_en            (seg_read[2]),
      .head             (seg_head[2]),
      .empty            (seg_empty[2]),
      .full_flag        (full_flag[2]),
      .almost_full_flag (almost_full_flag[2]),
      .fill_count       (cnt_thi)
   );
endmodule

// ### vcdf_pkg.sv
// Shared constants, types and register map of the video capture data buffer.
package vcdf_pkg;

   localparam int unsigned WORD_W    = 32;
   localparam int unsigned TAG_W     = 4;
   localparam int unsigned ENTRY_W   = WORD_W + TAG_W;
   localparam int unsigned TAG_LSB   = WORD_W;
   localparam int unsigned SEG_COUNT = 3;

   localparam int unsigned PRI_DEPTH   = 70;
   localparam int unsigned SEC_DEPTH   = 35;
   localparam int unsigned PRI_FULL    = 68;
   localparam int unsigned SEC_FULL    = 34;
   localparam int unsigned PRI_AFULL   = 64;
   localparam int unsigned SEC_AFULL   = 32;
   localparam int unsigned MERGED_SIZE = 140;

   localparam logic [3:0] TAG_PACKED_MARK = 4'h6;
   localparam logic [3:0] TAG_PLANAR_MARK = 4'hE;
   localparam logic [3:0] TAG_LINE_START  = 4'h2;
   localparam logic [3:0] TAG_END_4B      = 4'h1;
   localparam logic [3:0] TAG_END_3B      = 4'hD;
   localparam logic [3:0] TAG_END_2B      = 4'h9;
   localparam logic [3:0] TAG_END_1B      = 4'h5;
   localparam logic [3:0] TAG_EVEN_END    = 4'h4;
   localparam logic [3:0] TAG_ODD_END     = 4'hC;
   localparam logic [3:0] TAG_PLAIN       = 4'h0;

   localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
   localparam logic [31:0] ADDR_COUNT  = 32'h0000_0008;
   localparam logic [31:0] ADDR_MASK   = 32'h0000_00FC;
   localparam logic [2:0]  HSIZE_WORD  = 3'h2;
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
   localparam logic [1:0]  HRESP_OKAY  = 2'h0;

   localparam int unsigned CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

   // Control register layout, bit 4 downward.
   typedef struct packed {
      logic vbi_en;
      logic word_swap;
      logic byte_swap;
      logic planar;
      logic capture;
   } vcdf_ctrl_s;

   // Word presented by the pixel formatter; every field moves with the word.
   typedef struct packed {
      logic        vbi;
      logic        active;
      logic        line_start;
      logic        line_end;
      logic [1:0]  valid_bytes;
      logic [1:0]  plane;
      logic [31:0] formatter_pixel_word;
   } vcdf_pix_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MARK_A,
      ST_MARK_B,
      ST_FIELD_END,
      ST_WORD
   } vcdf_wr_state_e;

endpackage

// ### vcdf_capture_buffer_chk.sv
// Port assertions for the capture buffer.
`timescale 1ns/1ps
module vcdf_capture_buffer_chk
   import vcdf_pkg::*;
(
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hreadyout,
   input wire logic [1:0]           hresp,
   input wire logic [SEG_COUNT-1:0] seg_read,
   input wire logic [ENTRY_W-1:0]   seg_head [SEG_COUNT],
   input wire logic [SEG_COUNT-1:0] seg_empty,
   input wire logic [SEG_COUNT-1:0] full_flag,
   input wire logic [SEG_COUNT-1:0] almost_full_flag
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_ready_high: assert property (hreadyout && hresp == HRESP_OKAY)
      else $error("bus answer not ready and okay");
   chk_full_over_afull: assert property ((full_flag & ~almost_full_flag) == 3'h0)
      else $error("full without almost full");
   chk_full_not_empty: assert property ((full_flag & seg_empty) == 3'h0)
      else $error("full and empty together");
   chk_afull_not_empty: assert property ((almost_full_flag & seg_empty) == 3'h0)
      else $error("almost full and empty together");
   // Full is held below the physical size, so no drop-oldest can move the head here.
   chk_head_holds: assert property (!seg_read[0] && !seg_empty[0] && !full_flag[0]
      |=> $stable(seg_head[0])) else $error("head moved without a read");
   chk_empty_by_read: assert property ($rose(seg_empty[0]) |-> $past(seg_read[0]))
      else $error("segment emptied without a read");
   chk_full_drop_read: assert property ($fell(full_flag[1]) |-> $past(seg_read[1]))
      else $error("full cleared without a read");
   chk_tag_legal: assert property (!seg_empty[2] |-> seg_head[2][35:32] inside
      {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h9, 4'hC, 4'hD, 4'hE})
      else $error("undefined tag at head");
   chk_mark_no_data: assert property (!seg_empty[1] && seg_head[1][35:32] == 4'hE
      |-> seg_head[1][31:0] == 32'h0) else $error("marker carries data");
endmodule

bind vcdf_capture_buffer vcdf_capture_buffer_chk i_vcdf_capture_buffer_chk (
   .hclk             (hclk),
   .hresetn          (hresetn),
   .hreadyout        (hreadyout),
   .hresp            (hresp),
   .seg_read         (seg_read),
   .seg_head         (seg_head),
   .seg_empty        (seg_empty),
   .full_flag        (full_flag),
   .almost_full_flag (almost_full_flag)
);

// ### vcdf_fmt_model.sv
// Pixel formatter model driving the buffer's pixel port.
`timescale 1ns/1ps
module vcdf_fmt_model
   import vcdf_pkg::*;
(
   input  wire logic hclk,
   output vcdf_pix_s pix_in,
   output logic      pix_toggle
);
   initial
   begin
      pix_in = '0;
      pix_toggle = 1'b0;
   end
   // Word is scrambled once its hold ends so a stale value never looks held.
   task automatic send(input vcdf_pix_s p);
      pix_in <= p;
      @(posedge hclk);
      pix_toggle <= ~pix_toggle;
      repeat (5) @(posedge hclk);
      pix_in <= ~p;
      repeat (2) @(posedge hclk);
   endtask
endmodule

// ### testbench.sv
// Self-checking bench for the capture buffer.
`timescale 1ns/1ps
module testbench
   import vcdf_pkg::*;
;
   logic               hclk, hresetn, hsel, hwrite, hreadyout, pix_toggle, field_odd;
   logic [31:0]        haddr, hwdata, hrdata, rd, d;
   logic [1:0]         htrans, hresp;
   logic [2:0]         hsize, seg_read, seg_empty, full_flag, almost_full_flag;
   logic [ENTRY_W-1:0] seg_head [SEG_COUNT];
   logic [35:0]        exp_q [3][$];
   logic [3:0]         tg [4];
   vcdf_pix_s          pix_in, p;
   int                 bad_count, n_compared, c;

   vcdf_capture_buffer i_vcdf_capture_buffer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pix_in(pix_in), .pix_toggle(pix_toggle), .field_odd(field_odd), .seg_read(seg_read),
      .seg_head(seg_head), .seg_empty(seg_empty), .full_flag(full_flag),
      .almost_full_flag(almost_full_flag));
   vcdf_fmt_model i_vcdf_fmt_model (.hclk(hclk), .pix_in(pix_in), .pix_toggle(pix_toggle));

   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NSEQ;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   function automatic void put(int k, logic [3:0] t, logic [31:0] v);
      exp_q[k].push_back({t, v});
   endfunction

   function automatic logic [31:0] sw(logic [31:0] v, int s);
      case (s)
         1: return {v[23:16], v[31:24], v[7:0], v[15:8]};
         2: return {v[15:0], v[31:16]};
         3: return {v[7:0], v[15:8], v[23:16], v[31:24]};
         default: return v;
      endcase
   endfunction

   // Heads are compared at the falling edge, so a head launched by a read has settled.
   task automatic drain(input int k);
      @(negedge hclk);
      for (int n = 0; n < 90 && seg_empty[k] === 1'b0; n++)
      begin
         if (exp_q[k].size() > 0)
            check(seg_head[k], exp_q[k].pop_front());
         @(posedge hclk);
         seg_read <= 3'h1 << k;
         @(posedge hclk);
         seg_read <= 3'h0;
         @(negedge hclk);
      end
      check(40'(exp_q[k].size()), 40'h0);
      check(seg_empty[k], 1'b1);
   endtask

   task automatic marks(input logic [3:0] t);
      put(0, t, 32'h0);
      put(0, t, 32'h0);
      put(1, t, 32'h0);
      put(2, t, 32'h0);
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge hclk);
      bad_count++;
      stop_test;
   end

   initial
   begin
      {hresetn, hsel, hwrite, field_odd, haddr, hwdata, htrans, seg_read} = '0;
      hsize = HSIZE_WORD;
      tg = '{TAG_LINE_START, TAG_PLAIN, TAG_END_3B, TAG_END_4B};
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(seg_empty, 3'h7);
      ahb(1'b1, ADDR_CTRL, 32'h03, rd);
      marks(TAG_PLANAR_MARK);
      for (int s = 0; s < 4; s++)
      begin
         d = 32'h1234_5678 + 32'h0404_0404 * s;
         ahb(1'b1, ADDR_CTRL, 32'h03 | (s << 2), rd);
         p = '{1'b0, 1'b1, s == 0, s > 1, (s == 2) ? 2'h3 : 2'h0, 2'h0, d};
         i_vcdf_fmt_model.send(p);
         put(0, tg[s], sw(d, s));
         p.active = 1'b0;
         i_vcdf_fmt_model.send(p);
      end
      ahb(1'b1, ADDR_CTRL, 32'h1D, rd);
      marks(TAG_PACKED_MARK);
      p = '{1'b1, 1'b0, 1'b0, 1'b1, 2'h1, 2'h0, 32'hCAFE_0123};
      i_vcdf_fmt_model.send(p);
      put(0, TAG_END_1B, 32'hCAFE_0123);
      p = '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 32'h89AB_4567};
      i_vcdf_fmt_model.send(p);
      put(1, TAG_PLAIN, 32'h89AB_4567);
      field_odd <= 1'b1;
      repeat (10) @(posedge hclk);
      for (int k = 0; k < 3; k++)
         put(k, TAG_ODD_END, 32'h0);
      marks(TAG_PACKED_MARK);
      for (int k = 0; k < 3; k++)
         drain(k);
      $display("test tags_and_swaps done");
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, ADDR_STATUS, 32'h0, rd);
      check(rd, 32'h1C0);
      ahb(1'b1, ADDR_CTRL, 32'h03, rd);
      for (int k = 0; k < 3; k++)
         for (c = k ? 1 : 2; c < (k ? SEC_FULL : PRI_FULL); )
         begin
            p = '{1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 2'(k), 32'(c)};
            i_vcdf_fmt_model.send(p);
            c++;
            check({full_flag[k], almost_full_flag[k]},
                  {c >= (k ? SEC_FULL : PRI_FULL), c >= (k ? SEC_AFULL : PRI_AFULL)});
         end
      ahb(1'b0, ADDR_COUNT, 32'h0, rd);
      check(rd, (34 << 13) | (34 << 7) | 68);
      seg_read <= 3'h7;
      @(posedge hclk);
      seg_read <= 3'h0;
      ahb(1'b0, ADDR_COUNT, 32'h0, rd);
      check(rd, (33 << 13) | (33 << 7) | 67);
      check(full_flag, 3'h0);
      ahb(1'b0, 32'h10, 32'h0, rd);
      check(rd, 32'h0);
      $display("test fill_levels done");
      stop_test;
   end
endmodule
